// ---- rtl/chopper_defs.svh ----
// constants for the serial-programmed quad h-bridge chopper
`ifndef CHOPPER_DEFS_SVH
`define CHOPPER_DEFS_SVH
`define WORD_BITS 16
`define SEL0_BIT 14
`define SEL1_BIT 15
`define BLANK_LO 0
`define BLANK_HI 1
`define OFF_LO 2
`define OFF_HI 6
`define FAST_LO 7
`define FAST_HI 10
`define RECT_CTRL_BIT 11
`define RECT_EN_BIT 12
`define MODE_LO_BASE 0
`define MODE_HI_BASE 7
`define MODE_INT_DECAY 0
`define MODE_EXT_DECAY 1
`define MODE_PHASE 2
`define MODE_DAC_LO 3
`define MODE_DAC_HI 6
`define WORD_RESET 16'h0000
`define BLANK_00 5'h04
`define BLANK_01 5'h06
`define BLANK_10 5'h0c
`define BLANK_11 5'h18
`define OSC_DIV 4'h4
`define CLK_PERIOD_NS 25
`define UV_FILTER_NS 1000
`define UV_CYCLES ((`UV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_HALF_BIT 4'h4
`endif

// ---- rtl/chopper_pkg.sv ----
// shared types for the chopper and its serial link
package chopper_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_BLANK = 6'b000010,
        ST_ON    = 6'b000100,
        ST_FAST  = 6'b001000,
        ST_SLOW  = 6'b010000,
        ST_EXT   = 6'b100000
    } bridge_state_e;
    typedef enum logic [2:0] {
        HS_IDLE   = 3'b001,
        HS_SHIFT  = 3'b010,
        HS_STROBE = 3'b100
    } host_state_e;
endpackage

// ---- rtl/serial_link_if.sv ----
// pins between the host controller and the bridge driver
interface serial_link_if;
    logic port_a_serial_clock;
    logic port_a_serial_data;
    logic port_a_latch_strobe;
    logic port_b_serial_clock;
    logic port_b_serial_data;
    logic port_b_latch_strobe;
    logic pair_a_drive_enable;
    logic pair_b_drive_enable;
    logic reset_pin_n;
    modport device_end (
        input port_a_serial_clock, port_a_serial_data, port_a_latch_strobe,
        input port_b_serial_clock, port_b_serial_data, port_b_latch_strobe,
        input pair_a_drive_enable, pair_b_drive_enable, reset_pin_n
    );
    modport host_end (
        output port_a_serial_clock, port_a_serial_data, port_a_latch_strobe,
        output port_b_serial_clock, port_b_serial_data, port_b_latch_strobe,
        output pair_a_drive_enable, pair_b_drive_enable, reset_pin_n
    );
endinterface

// ---- rtl/chopper_host.sv ----
// host end: shifts 16-bit words out on either serial port and drives enables
`include "chopper_defs.svh"
module chopper_host (
    input wire logic clock,
    input wire logic sys_rst,
    serial_link_if.host_end link,
    input wire logic [15:0] word_data,
    input wire logic word_port_b,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic drive_enable_a,
    input wire logic drive_enable_b,
    input wire logic hold_reset
);
    chopper_pkg::host_state_e state_reg;
    logic [15:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic [3:0] div_reg;
    logic sclk_reg;
    logic port_b_reg;
    logic strobe_reg;
    logic half_tick;

    // half-bit divider derives the serial clock from the system clock
    assign half_tick = (div_reg == `HOST_HALF_BIT - 4'h1);
    always_ff @(posedge clock)
    begin
        if (sys_rst || state_reg == chopper_pkg::HS_IDLE)
            div_reg <= 4'h0;
        else
            div_reg <= half_tick ? 4'h0 : div_reg + 4'h1;
    end

    // word sequencer: data changes while the clock is low, msb first
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_reg <= chopper_pkg::HS_IDLE;
            shift_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            sclk_reg <= 1'b0;
            port_b_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                chopper_pkg::HS_IDLE:
                    if (word_valid)
                    begin
                        shift_reg <= word_data;
                        port_b_reg <= word_port_b;
                        bit_cnt_reg <= 5'h00;
                        state_reg <= chopper_pkg::HS_SHIFT;
                    end
                chopper_pkg::HS_SHIFT:
                    if (half_tick)
                    begin
                        sclk_reg <= ~sclk_reg;
                        if (sclk_reg)
                        begin
                            shift_reg <= {shift_reg[14:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == 5'h0f)
                            begin
                                strobe_reg <= 1'b1;
                                state_reg <= chopper_pkg::HS_STROBE;
                            end
                        end
                    end
                chopper_pkg::HS_STROBE:
                    if (half_tick)
                    begin
                        strobe_reg <= 1'b0;
                        state_reg <= chopper_pkg::HS_IDLE;
                    end
            endcase
        end
    end

    assign word_ready = (state_reg == chopper_pkg::HS_IDLE);
    assign link.port_a_serial_clock = sclk_reg & ~port_b_reg;
    assign link.port_b_serial_clock = sclk_reg & port_b_reg;
    assign link.port_a_serial_data = shift_reg[15] & ~port_b_reg;
    assign link.port_b_serial_data = shift_reg[15] & port_b_reg;
    assign link.port_a_latch_strobe = strobe_reg & ~port_b_reg;
    assign link.port_b_latch_strobe = strobe_reg & port_b_reg;
    assign link.pair_a_drive_enable = drive_enable_a;
    assign link.pair_b_drive_enable = drive_enable_b;
    assign link.reset_pin_n = ~(hold_reset | sys_rst);
endmodule

// ---- rtl/chopper_device.sv ----
// device end: serial word capture, configuration and four-bridge current chopper
`include "chopper_defs.svh"
module chopper_device (
    input wire logic clock,
    input wire logic sys_rst,
    serial_link_if.device_end link,
    input wire logic thermal_shutdown,
    input wire logic supply_ok,
    input wire logic [3:0] current_trip,
    input wire logic [3:0] decay_detect,
    output logic [3:0] high_a,
    output logic [3:0] low_a,
    output logic [3:0] high_b,
    output logic [3:0] low_b,
    output logic [3:0] detect_passive,
    output logic [15:0] trip_ratio_code
);
    logic [18:0] pin_raw;
    logic [18:0] pin_meta;
    logic [18:0] pin_s;
    logic [3:0] osc_cnt_reg;
    logic osc_tick;
    logic [6:0] uv_cnt_reg;
    logic cfg_clear;
    logic [1:0] sclk_prev_reg;
    logic [1:0] stb_prev_reg;
    logic [15:0] shift_reg [0:1];
    logic [1:0] latch;
    logic [15:0] timing_word_reg [0:2];
    logic [15:0] mode_a_reg;
    logic [15:0] mode_b_reg;
    logic [2:0] timing_seen_reg;
    logic [1:0] mode_seen_reg;
    logic ready_a;
    logic ready_b;

    // every outside signal passes two flops before use
    // bit map: 0-2 port a, 3-5 port b, 6-7 enables, 8 reset, 9 overheat, 10 supply, 11-14 trip, 15-18 detect
    assign pin_raw = {decay_detect, current_trip, supply_ok, thermal_shutdown, link.reset_pin_n,
                      link.pair_b_drive_enable, link.pair_a_drive_enable,
                      link.port_b_latch_strobe, link.port_b_serial_data, link.port_b_serial_clock,
                      link.port_a_latch_strobe, link.port_a_serial_data, link.port_a_serial_clock};
    always_ff @(posedge clock)
    begin
        pin_meta <= pin_raw;
        pin_s <= pin_meta;
    end

    // internal oscillator tick shared by every bridge timer
    assign osc_tick = (osc_cnt_reg == `OSC_DIV - 4'h1);
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            osc_cnt_reg <= 4'h0;
        else
            osc_cnt_reg <= osc_tick ? 4'h0 : osc_cnt_reg + 4'h1;
    end

    // undervoltage filter: a dip must last the full window to reset
    always_ff @(posedge clock)
    begin
        if (sys_rst || pin_s[10])
            uv_cnt_reg <= 7'h00;
        else if (uv_cnt_reg != 7'(`UV_CYCLES))
            uv_cnt_reg <= uv_cnt_reg + 7'h01;
    end
    assign cfg_clear = sys_rst | ~pin_s[8] | pin_s[9] | (uv_cnt_reg == 7'(`UV_CYCLES));

    // per-port shift register on serial clock rising edges
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                begin
                    sclk_prev_reg[p] <= 1'b0;
                    stb_prev_reg[p] <= 1'b0;
                    shift_reg[p] <= `WORD_RESET;
                end
                else
                begin
                    sclk_prev_reg[p] <= pin_s[p*3];
                    stb_prev_reg[p] <= pin_s[p*3+2];
                    if (pin_s[p*3] && !sclk_prev_reg[p])
                        shift_reg[p] <= {shift_reg[p][14:0], pin_s[p*3+1]};
                end
            end
            assign latch[p] = pin_s[p*3+2] && !stb_prev_reg[p];
        end
    endgenerate

    // word select decode into the configuration words
    always_ff @(posedge clock)
    begin
        if (cfg_clear)
        begin
            timing_word_reg[0] <= `WORD_RESET;
            timing_word_reg[1] <= `WORD_RESET;
            timing_word_reg[2] <= `WORD_RESET;
            mode_a_reg <= `WORD_RESET;
            mode_b_reg <= `WORD_RESET;
            timing_seen_reg <= 3'h0;
            mode_seen_reg <= 2'h0;
        end
        else
        begin
            if (latch[0])
            begin
                if (shift_reg[0][`SEL1_BIT])
                begin
                    mode_a_reg <= shift_reg[0];
                    mode_seen_reg[0] <= 1'b1;
                end
                else if (shift_reg[0][`SEL0_BIT])
                begin
                    timing_word_reg[1] <= shift_reg[0];
                    timing_seen_reg[1] <= 1'b1;
                end
                else
                begin
                    timing_word_reg[0] <= shift_reg[0];
                    timing_seen_reg[0] <= 1'b1;
                end
            end
            if (latch[1])
            begin
                if (shift_reg[1][`SEL1_BIT])
                begin
                    mode_b_reg <= shift_reg[1];
                    mode_seen_reg[1] <= 1'b1;
                end
                else if (!shift_reg[1][`SEL0_BIT])
                begin
                    timing_word_reg[2] <= shift_reg[1];
                    timing_seen_reg[2] <= 1'b1;
                end
            end
        end
    end
    assign ready_a = &{timing_seen_reg[1:0], mode_seen_reg[0]};
    assign ready_b = timing_seen_reg[2] & mode_seen_reg[1];

    // one chopper per bridge: 0 and 1 on port a, 2 and 3 on port b
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_bridge
            chopper_pkg::bridge_state_e state_reg;
            logic [15:0] tw;
            logic [6:0] mf;
            logic en;
            logic ready;
            logic int_slow;
            logic ext_slow;
            logic rect_en;
            logic [4:0] blank_cnt_reg;
            logic [7:0] off_cnt_reg;
            logic [6:0] fast_cnt_reg;
            logic [4:0] blank_load;
            logic blank_done;
            logic off_done;
            logic fast_done;
            logic armed;
            logic all_off_reg;
            logic [3:0] drive_next;

            assign tw = timing_word_reg[(i < 2) ? i : 2];
            assign mf = (i % 2 == 0) ? ((i < 2) ? mode_a_reg[13:7] : mode_b_reg[13:7])
                                     : ((i < 2) ? mode_a_reg[6:0] : mode_b_reg[6:0]);
            assign en = (i < 2) ? pin_s[6] : pin_s[7];
            assign ready = (i < 2) ? ready_a : ready_b;
            assign int_slow = mf[`MODE_INT_DECAY];
            assign ext_slow = (i < 2) ? mf[`MODE_EXT_DECAY] : 1'b0;
            assign rect_en = tw[`RECT_EN_BIT];
            assign blank_load = tw[`BLANK_LO] ? (tw[`BLANK_HI] ? `BLANK_11 : `BLANK_10)
                                              : (tw[`BLANK_HI] ? `BLANK_01 : `BLANK_00);
            assign blank_done = osc_tick && blank_cnt_reg == 5'h01;
            assign off_done = osc_tick && off_cnt_reg == 8'h01;
            assign fast_done = osc_tick && fast_cnt_reg == 7'h01;

            // bridge sequence: blank, on, fast decay, slow decay, repeat
            always_ff @(posedge clock)
            begin
                if (cfg_clear || !ready || mf[`MODE_DAC_HI:`MODE_DAC_LO] == 4'h0)
                    state_reg <= chopper_pkg::ST_IDLE;
                else if (!en)
                    state_reg <= chopper_pkg::ST_EXT;
                else
                begin
                    unique case (state_reg)
                        chopper_pkg::ST_IDLE, chopper_pkg::ST_EXT:
                            state_reg <= chopper_pkg::ST_BLANK;
                        chopper_pkg::ST_BLANK:
                            if (blank_done)
                                state_reg <= chopper_pkg::ST_ON;
                        chopper_pkg::ST_ON:
                            if (pin_s[11+i])
                                state_reg <= int_slow ? chopper_pkg::ST_SLOW : chopper_pkg::ST_FAST;
                        chopper_pkg::ST_FAST:
                            if (off_done)
                                state_reg <= chopper_pkg::ST_BLANK;
                            else if (fast_done)
                                state_reg <= chopper_pkg::ST_SLOW;
                        chopper_pkg::ST_SLOW:
                            if (off_done)
                                state_reg <= chopper_pkg::ST_BLANK;
                    endcase
                end
            end

            // interval timers, each loaded then counted down on the tick
            always_ff @(posedge clock)
            begin
                if (state_reg != chopper_pkg::ST_BLANK)
                    blank_cnt_reg <= blank_load;
                else if (osc_tick)
                    blank_cnt_reg <= blank_cnt_reg - 5'h01;
                if (state_reg == chopper_pkg::ST_ON || state_reg == chopper_pkg::ST_EXT)
                begin
                    off_cnt_reg <= {tw[`OFF_HI:`OFF_LO], 3'h7};
                    fast_cnt_reg <= {tw[`FAST_HI:`FAST_LO], 3'h7};
                end
                else if (osc_tick)
                begin
                    if (off_cnt_reg != 8'h00)
                        off_cnt_reg <= off_cnt_reg - 8'h01;
                    if (fast_cnt_reg != 7'h00)
                        fast_cnt_reg <= fast_cnt_reg - 7'h01;
                end
            end

            // decay current detection window and all-off latch
            assign armed = rect_en && ((state_reg == chopper_pkg::ST_FAST && !int_slow)
                           || (state_reg == chopper_pkg::ST_EXT && !ext_slow));
            always_ff @(posedge clock)
            begin
                if (!armed)
                    all_off_reg <= 1'b0;
                else if (pin_s[15+i])
                    all_off_reg <= 1'b1;
            end

            // gate pattern {high_a, low_a, high_b, low_b}
            always_comb
            begin
                drive_next = 4'h0;
                unique case (state_reg)
                    chopper_pkg::ST_BLANK, chopper_pkg::ST_ON:
                        drive_next = mf[`MODE_PHASE] ? 4'b1001 : 4'b0110;
                    chopper_pkg::ST_FAST:
                        if (rect_en && !all_off_reg)
                            drive_next = mf[`MODE_PHASE] ? 4'b0110 : 4'b1001;
                    chopper_pkg::ST_SLOW:
                        if (rect_en)
                            drive_next = 4'b0101;
                    chopper_pkg::ST_EXT:
                        if (ext_slow && rect_en)
                            drive_next = 4'b0101;
                        else if (!ext_slow && rect_en && !all_off_reg)
                            drive_next = mf[`MODE_PHASE] ? 4'b0110 : 4'b1001;
                    default:
                        drive_next = 4'h0;
                endcase
            end

            // registered gate and reference outputs
            always_ff @(posedge clock)
            begin
                if (cfg_clear)
                begin
                    {high_a[i], low_a[i], high_b[i], low_b[i]} <= 4'h0;
                    detect_passive[i] <= 1'b0;
                    trip_ratio_code[i*4 +: 4] <= 4'h0;
                end
                else
                begin
                    {high_a[i], low_a[i], high_b[i], low_b[i]} <= drive_next;
                    detect_passive[i] <= tw[`RECT_CTRL_BIT];
                    trip_ratio_code[i*4 +: 4] <= mf[`MODE_DAC_HI:`MODE_DAC_LO];
                end
            end
        end
    endgenerate
endmodule

// ---- bench/serial_link_chk.sv ----
// concurrent checks on the serial link as driven by the host end
module serial_link_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic port_a_serial_clock,
    input wire logic port_a_serial_data,
    input wire logic port_a_latch_strobe,
    input wire logic port_b_serial_clock,
    input wire logic port_b_serial_data,
    input wire logic port_b_latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_a_q;
    logic clk_b_q;
    logic [4:0] bits_a;
    logic [4:0] bits_b;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // remembers last serial clock levels to find rising edges
    always_ff @(posedge clock)
    begin
        clk_a_q <= port_a_serial_clock;
        clk_b_q <= port_b_serial_clock;
    end
    // counts serial clock rises since the last strobe on each port
    always_ff @(posedge clock)
    begin
        if (sys_rst || port_a_latch_strobe)
            bits_a <= 5'h00;
        else if (port_a_serial_clock && !clk_a_q)
            bits_a <= bits_a + 5'h01;
        if (sys_rst || port_b_latch_strobe)
            bits_b <= 5'h00;
        else if (port_b_serial_clock && !clk_b_q)
            bits_b <= bits_b + 5'h01;
    end
    a_strobe_width: assert property (
        $rose(port_a_latch_strobe) |-> port_a_latch_strobe [*4] ##1 !port_a_latch_strobe)
        else $error("port a strobe width wrong");
    a_bit_count_a: assert property (
        $rose(port_a_latch_strobe) |-> bits_a == 5'h10)
        else $error("port a word not sixteen bits");
    a_bit_count_b: assert property (
        $rose(port_b_latch_strobe) |-> bits_b == 5'h10)
        else $error("port b word not sixteen bits");
    a_clock_high_time: assert property (
        $rose(port_a_serial_clock) |-> port_a_serial_clock [*4] ##1 !port_a_serial_clock)
        else $error("port a serial clock high time wrong");
    a_clock_low_time: assert property (
        $fell(port_b_serial_clock) |-> !port_b_serial_clock [*4])
        else $error("port b serial clock low time short");
    a_data_held_high: assert property (
        port_a_serial_clock |-> $stable(port_a_serial_data))
        else $error("port a data moved while clock high");
    a_strobe_clock_low: assert property (
        (port_a_latch_strobe || port_b_latch_strobe) |-> !(port_a_serial_clock || port_b_serial_clock))
        else $error("serial clock high during strobe");
    a_one_port_busy: assert property (
        (port_a_serial_clock || port_a_latch_strobe) |-> !(port_b_serial_clock || port_b_latch_strobe))
        else $error("both ports active at once");
    c_word_a: cover property ($rose(port_a_latch_strobe));
    c_word_b: cover property ($rose(port_b_latch_strobe));
    c_full_b: cover property ($rose(port_b_latch_strobe) && bits_b == 5'h10);
endmodule

// ---- bench/serial_bridge_chopper_control_test.sv ----
// self-checking bench: host end and device end joined on the serial link
module serial_bridge_chopper_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, word_port_b, word_valid, word_ready, prev_a, prev_b;
    logic drive_enable_a, drive_enable_b, hold_reset, thermal_shutdown, supply_ok;
    logic [3:0] current_trip, decay_detect, high_a, low_a, high_b, low_b, detect_passive;
    logic [15:0] word_data, trip_ratio_code, shift_a, shift_b;
    int n_mismatch, checks, fast, gap, i;
    serial_link_if i_serial_link_if ();
    chopper_host i_chopper_host (.clock(clock), .sys_rst(sys_rst), .link(i_serial_link_if.host_end),
        .word_data(word_data), .word_port_b(word_port_b), .word_valid(word_valid),
        .word_ready(word_ready), .drive_enable_a(drive_enable_a), .drive_enable_b(drive_enable_b),
        .hold_reset(hold_reset));
    chopper_device i_chopper_device (.clock(clock), .sys_rst(sys_rst), .link(i_serial_link_if.device_end),
        .thermal_shutdown(thermal_shutdown), .supply_ok(supply_ok), .current_trip(current_trip),
        .decay_detect(decay_detect), .high_a(high_a), .low_a(low_a), .high_b(high_b), .low_b(low_b),
        .detect_passive(detect_passive), .trip_ratio_code(trip_ratio_code));
    serial_link_chk i_serial_link_chk (.clock(clock), .sys_rst(sys_rst),
        .port_a_serial_clock(i_serial_link_if.port_a_serial_clock),
        .port_a_serial_data(i_serial_link_if.port_a_serial_data),
        .port_a_latch_strobe(i_serial_link_if.port_a_latch_strobe),
        .port_b_serial_clock(i_serial_link_if.port_b_serial_clock),
        .port_b_serial_data(i_serial_link_if.port_b_serial_data),
        .port_b_latch_strobe(i_serial_link_if.port_b_latch_strobe));
    // 40 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // rebuilds each word from the pins, sampled on serial clock rises
    always @(posedge clock)
    begin
        prev_a <= i_serial_link_if.port_a_serial_clock;
        prev_b <= i_serial_link_if.port_b_serial_clock;
        if (i_serial_link_if.port_a_serial_clock && !prev_a)
            shift_a <= {shift_a[14:0], i_serial_link_if.port_a_serial_data};
        if (i_serial_link_if.port_b_serial_clock && !prev_b)
            shift_b <= {shift_b[14:0], i_serial_link_if.port_b_serial_data};
    end
    // gate levels of one bridge as high_a, low_a, high_b, low_b
    function automatic logic [3:0] gate(input int k);
        return {high_a[k], low_a[k], high_b[k], low_b[k]};
    endfunction
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // a wait that ran out of bound ends the run
    task bound(input string name, input logic ok);
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("Error %s expected done seen timeout", name);
            stop_test;
        end
    endtask
    // one word through the host end, then compare what crossed the wire
    task send(input logic [15:0] w, input logic pb);
        int k;
        @(posedge clock);
        word_data <= w;
        word_port_b <= pb;
        word_valid <= 1'b1;
        @(negedge clock);
        for (k = 0; k < 20 && word_ready !== 1'b0; k++) @(negedge clock);
        bound("word_taken", word_ready === 1'b0);
        @(posedge clock);
        word_valid <= 1'b0;
        for (k = 0; k < 400 && word_ready !== 1'b1; k++) @(negedge clock);
        bound("word_sent", word_ready === 1'b1);
        check("shifted_word", pb ? shift_b : shift_a, w);
    endtask
    // all words of both ports, the test word last
    task setup;
        send(16'h1004, 1'b0);
        repeat (8) @(posedge clock);
        check("gates_before_mode", {high_a, low_a, high_b, low_b}, 16'h0000);
        send(16'h5804, 1'b0);
        send(16'hbe2a, 1'b0);
        send(16'h1004, 1'b1);
        send(16'h8f06, 1'b1);
        send(16'h4fff, 1'b1);
        repeat (8) @(posedge clock);
        check("ratio_codes", trip_ratio_code, 16'h035f);
    endtask
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        word_data = 16'h0000;
        word_port_b = 1'b0;
        word_valid = 1'b0;
        drive_enable_a = 1'b1;
        drive_enable_b = 1'b1;
        hold_reset = 1'b0;
        thermal_shutdown = 1'b0;
        supply_ok = 1'b1;
        current_trip = 4'h0;
        decay_detect = 4'h0;
        n_mismatch = 0;
        checks = 0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        setup;
        check("passive_flags", detect_passive, 4'h2);
        for (i = 0; i < 200 && gate(0) !== 4'h9; i++) @(negedge clock);
        bound("bridge0_on", gate(0) === 4'h9);
        check("bridge1_on", gate(1), 4'h6);
        check("bridge2_on", gate(2), 4'h9);
        check("bridge3_off", gate(3), 4'h0);
        repeat (40) @(posedge clock);
        current_trip <= 4'h1;
        repeat (2) @(posedge clock);
        current_trip <= 4'h0;
        fast = 0;
        gap = 0;
        for (i = 0; i < 400; i++)
        begin
            @(negedge clock);
            if (gate(0) === 4'h6)
                fast++;
            if (high_a[0] === 1'b0)
                gap++;
            else if (gap > 0)
                break;
        end
        check("fast_decay_len", 16'(fast >= 25 && fast <= 28), 16'h0001);
        check("off_time_len", 16'(gap >= 56 && gap <= 68), 16'h0001);
        // a trip that comes and goes inside the blanking interval is masked
        @(posedge clock);
        current_trip <= 4'h1;
        repeat (4) @(posedge clock);
        current_trip <= 4'h0;
        repeat (8) @(negedge clock);
        check("blank_masks_trip", gate(0), 4'h9);
        drive_enable_a <= 1'b0;
        drive_enable_b <= 1'b0;
        repeat (12) @(posedge clock);
        check("ext_fast", gate(0), 4'h6);
        check("ext_slow", gate(1), 4'h5);
        check("ignored_ext_bit", gate(2), 4'h6);
        decay_detect <= 4'h1;
        repeat (8) @(posedge clock);
        check("detect_all_off", gate(0), 4'h0);
        decay_detect <= 4'h0;
        drive_enable_a <= 1'b1;
        for (i = 0; i < 100 && gate(0) !== 4'h9; i++) @(negedge clock);
        bound("restart_on", gate(0) === 4'h9);
        supply_ok <= 1'b0;
        repeat (20) @(posedge clock);
        supply_ok <= 1'b1;
        repeat (10) @(posedge clock);
        check("short_dip", trip_ratio_code, 16'h035f);
        supply_ok <= 1'b0;
        repeat (50) @(posedge clock);
        supply_ok <= 1'b1;
        repeat (10) @(posedge clock);
        check("long_dip", trip_ratio_code, 16'h0000);
        check("long_dip_gates", {high_a, low_a, high_b, low_b}, 16'h0000);
        setup;
        thermal_shutdown <= 1'b1;
        repeat (10) @(posedge clock);
        thermal_shutdown <= 1'b0;
        repeat (4) @(posedge clock);
        check("overheat_codes", trip_ratio_code, 16'h0000);
        check("overheat_flags", detect_passive, 4'h0);
        setup;
        hold_reset <= 1'b1;
        repeat (10) @(posedge clock);
        check("pin_reset_codes", trip_ratio_code, 16'h0000);
        check("pin_reset_gates", {high_a, low_a, high_b, low_b}, 16'h0000);
        hold_reset <= 1'b0;
        repeat (10) @(posedge clock);
        stop_test;
    end
endmodule
